/* File: src/dag_defs.svh */
// Constants for the data address generator
`ifndef DAG_DEFS_SVH
`define DAG_DEFS_SVH
`define DAG_EXT_BASE 16'hc000
`define DAG_Y_BIT 2
`define DAG_ONE 16'h0001
`define DAG_ONE18 18'h00001
`define DAG_ZERO18 18'h00000
`define DAG_WAIT_X_LSB 0
`define DAG_WAIT_X_MSB 1
`define DAG_WAIT_Y_LSB 2
`define DAG_WAIT_Y_MSB 3
`define DAG_WAIT_C0 3'h0
`define DAG_WAIT_C1 3'h1
`define DAG_WAIT_C3 3'h3
`define DAG_WAIT_C7 3'h7
`define DAG_WAIT_ZERO 3'h0
`define DAG_WAIT_STEP 3'h1
`define DAG_RST_WORD 16'h0000
`endif

/* File: src/dag_pkg.sv */
// Types and shared functions of the data address generator
package dag_pkg;
  `include "dag_defs.svh"

  typedef enum logic [2:0] {
    MODE_HOLD, MODE_INC, MODE_DEC, MODE_INDEX, MODE_MODULO, MODE_BITREV, MODE_IMM
  } mode_t;

  typedef enum logic [2:0] {
    TGT_POINTER, TGT_INDEX, TGT_XMOD, TGT_YMOD, TGT_WAIT
  } cfg_target_t;

  typedef enum logic {ST_IDLE, ST_ACCESS} dag_state_t;

  typedef struct packed {
    dag_state_t st;
    logic [7:0][15:0] ptr;
    logic [7:0][15:0] idx;
    logic [15:0] modX;
    logic [15:0] modY;
    logic [15:0] waitCfg;
    logic [15:0] addr;
    logic strobe;
    logic ySel;
    logic ext;
    logic [2:0] cur;
    mode_t mode;
    logic [15:0] imm;
    logic [15:0] rdData;
  } dag_regs_t;

  typedef struct packed {
    logic [1:0] sync;
    logic [2:0] cnt;
    logic ext;
  } wait_regs_t;

  function automatic logic [15:0] bitReverse(input logic [15:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++)
    begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction : bitReverse

  // All ones from the top set bit down: mask + 1 is the least power of two >= limit + 1
  function automatic logic [15:0] modMask(input logic [15:0] lim);
    logic [15:0] r;
    r = lim;
    r = r | (r >> 1);
    r = r | (r >> 2);
    r = r | (r >> 4);
    r = r | (r >> 8);
    return r;
  endfunction : modMask

  function automatic logic [2:0] waitCycles(input logic [1:0] code);
    logic [2:0] r;
    r = `DAG_WAIT_C0;
    unique case (code)
      2'h0: r = `DAG_WAIT_C0;
      2'h1: r = `DAG_WAIT_C1;
      2'h2: r = `DAG_WAIT_C3;
      2'h3: r = `DAG_WAIT_C7;
    endcase
    return r;
  endfunction : waitCycles
endpackage : dag_pkg

/* File: src/wait_ctl.sv */
// Wait cycle counter and wait request pin synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "dag_defs.svh"
module wait_ctl (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Access start
  input wire logic start,
  input wire logic ext,
  input wire logic [2:0] cycles,
  // Pin
  input wire logic waitPin,
  // Status
  output logic finished,
  output logic [2:0] left
);
  import dag_pkg::*;

  wait_regs_t s_r;
  wait_regs_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sync = {s_r.sync[0], waitPin};
    if (start)
    begin
      s_nxt.cnt = cycles;
      s_nxt.ext = ext;
    end
    else if (s_r.cnt != `DAG_WAIT_ZERO)
    begin
      s_nxt.cnt = s_r.cnt - `DAG_WAIT_STEP;
    end
  end

  // Internal accesses ignore the pin
  assign finished = (s_r.cnt == `DAG_WAIT_ZERO) && !(s_r.ext && s_r.sync[1]);
  assign left = s_r.cnt;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end

  property p_load;
    @(posedge clk) disable iff (rst) (start && ce) |=> (left == $past(cycles));
  endproperty
  a_load: assert property (p_load) else $error("wait count not loaded");

  property p_pinHolds;
    @(posedge clk) disable iff (rst) (s_r.ext && s_r.sync[1]) |-> !finished;
  endproperty
  a_pinHolds: assert property (p_pinHolds) else $error("finished with wait pin held");
endmodule : wait_ctl
`default_nettype wire

/* File: src/data_address_generator.sv */
// Data address generator with post-access pointer update and external waits
// Notes on behaviour
// - Pointer updates after its access; next instruction sees the new value.
// - Pointers are modified only by an accepted memory access or a direct load from the core.
// - Hold, post-increment by one, or post-decrement by one.
// - Index mode adds the index register of the same number.
// - X modulo: low part plus index, modulo X limit plus one, high kept.
// - Y pointers use the Y modulo limit plus one instead.
// - Bit-reverse mode addresses with reversed pointer, then adds the index.
// - Any pointer can add the instruction's immediate value.
// - Pointers 0 to 3 address X memory with all seven modes.
// - Pointers 4 to 7 address Y memory with the same modes.
// - External wait setting lives in a 16-bit wait register.
// - Accesses from c000 to ffff get 0, 1, 3 or 7 waits.
// - Wait request pin held by memory extends the external access.
`timescale 1ns/1ps
`default_nettype none
`include "dag_defs.svh"
module data_address_generator (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Access request from the core
  input wire logic accValid,
  output logic accReady,
  input wire logic [2:0] accPtr,
  input wire dag_pkg::mode_t accMode,
  input wire logic [15:0] accImm,
  output logic accDone,
  // Data memory side
  output logic [15:0] memAddr,
  output logic memStrobe,
  output logic memYSel,
  output logic memExt,
  input wire logic waitReqPin,
  // Core register writes
  input wire logic cfgWrEn,
  input wire dag_pkg::cfg_target_t cfgWrTarget,
  input wire logic [2:0] cfgWrIdx,
  input wire logic [15:0] cfgWrData,
  // Pointer readback
  input wire logic [2:0] rdIdx,
  output logic [15:0] rdPtr
);
  import dag_pkg::*;

  dag_regs_t s_r;
  dag_regs_t s_nxt;
  logic [15:0] effAddr;
  logic extNow;
  logic [1:0] waitCode;
  logic waitStart;
  logic waitFinished;
  logic [2:0] waitLeft;

  function automatic logic [15:0] nextPtr(input logic [15:0] ptr, input logic [15:0] idx,
                                          input logic [15:0] lim, input mode_t mode,
                                          input logic [15:0] imm);
    logic [15:0] r;
    logic [15:0] m;
    logic signed [17:0] sum;
    logic signed [17:0] modulus;
    r = ptr;
    m = modMask(lim);
    modulus = $signed({2'b00, lim}) + $signed(`DAG_ONE18);
    sum = $signed({2'b00, ptr & m}) + $signed({{2{idx[15]}}, idx});
    unique case (mode)
      MODE_HOLD: r = ptr;
      MODE_INC: r = ptr + `DAG_ONE;
      MODE_DEC: r = ptr - `DAG_ONE;
      MODE_INDEX: r = ptr + idx;
      MODE_BITREV: r = ptr + idx;
      MODE_IMM: r = ptr + imm;
      MODE_MODULO:
      begin
        // Single correction step: index magnitude must not exceed the modulus
        if (sum >= modulus)
        begin
          sum = sum - modulus;
        end
        else if (sum < $signed(`DAG_ZERO18))
        begin
          sum = sum + modulus;
        end
        r = (ptr & ~m) | (sum[15:0] & m);
      end
      // Unused mode code leaves the pointer alone
      default: r = ptr;
    endcase
    return r;
  endfunction : nextPtr

  assign accReady = (s_r.st == ST_IDLE);
  assign waitStart = ce && accValid && accReady;
  assign effAddr = (accMode == MODE_BITREV) ? bitReverse(s_r.ptr[accPtr]) : s_r.ptr[accPtr];
  assign extNow = (effAddr >= `DAG_EXT_BASE);
  assign waitCode = accPtr[`DAG_Y_BIT] ? s_r.waitCfg[`DAG_WAIT_Y_MSB:`DAG_WAIT_Y_LSB]
                                       : s_r.waitCfg[`DAG_WAIT_X_MSB:`DAG_WAIT_X_LSB];
  assign accDone = ce && (s_r.st == ST_ACCESS) && waitFinished;

  wait_ctl u_wait (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .start(waitStart),
    .ext(extNow),
    .cycles(extNow ? waitCycles(waitCode) : `DAG_WAIT_ZERO),
    .waitPin(waitReqPin),
    .finished(waitFinished),
    .left(waitLeft)
  );

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rdData = s_r.ptr[rdIdx];
    unique case (s_r.st)
      ST_IDLE:
      begin
        if (accValid)
        begin
          s_nxt.addr = effAddr;
          s_nxt.strobe = 1'b1;
          s_nxt.ySel = accPtr[`DAG_Y_BIT];
          s_nxt.ext = extNow;
          s_nxt.cur = accPtr;
          s_nxt.mode = accMode;
          s_nxt.imm = accImm;
          s_nxt.st = ST_ACCESS;
        end
      end
      ST_ACCESS:
      begin
        // Update only when the access ends, so the address used is the old one
        if (waitFinished)
        begin
          s_nxt.ptr[s_r.cur] = nextPtr(s_r.ptr[s_r.cur], s_r.idx[s_r.cur],
                                       s_r.ySel ? s_r.modY : s_r.modX,
                                       s_r.mode, s_r.imm);
          s_nxt.strobe = 1'b0;
          s_nxt.st = ST_IDLE;
        end
      end
    endcase
    // A direct load from the core overrides a same-cycle pointer update
    if (cfgWrEn)
    begin
      unique case (cfgWrTarget)
        TGT_POINTER: s_nxt.ptr[cfgWrIdx] = cfgWrData;
        TGT_INDEX: s_nxt.idx[cfgWrIdx] = cfgWrData;
        TGT_XMOD: s_nxt.modX = cfgWrData;
        TGT_YMOD: s_nxt.modY = cfgWrData;
        TGT_WAIT: s_nxt.waitCfg = cfgWrData;
        default: s_nxt.modX = s_r.modX;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end

  assign memAddr = s_r.addr;
  assign memStrobe = s_r.strobe;
  assign memYSel = s_r.ySel;
  assign memExt = s_r.ext;
  assign rdPtr = s_r.rdData;

  property p_noModWithoutAccess;
    @(posedge clk) disable iff (rst) (ce && !accDone && !cfgWrEn) |=> (s_r.ptr == $past(s_r.ptr));
  endproperty
  a_noModWithoutAccess: assert property (p_noModWithoutAccess) else $error("pointer moved");

  property p_inc;
    @(posedge clk) disable iff (rst) (accDone && s_r.mode == MODE_INC && !cfgWrEn)
      |=> (s_r.ptr[$past(s_r.cur)] == $past(s_r.ptr[s_r.cur]) + `DAG_ONE);
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");

  property p_dec;
    @(posedge clk) disable iff (rst) (accDone && s_r.mode == MODE_DEC && !cfgWrEn)
      |=> (s_r.ptr[$past(s_r.cur)] == $past(s_r.ptr[s_r.cur]) - `DAG_ONE);
  endproperty
  a_dec: assert property (p_dec) else $error("decrement wrong");

  property p_index;
    @(posedge clk) disable iff (rst) (accDone && s_r.mode == MODE_INDEX && !cfgWrEn)
      |=> (s_r.ptr[$past(s_r.cur)] == $past(s_r.ptr[s_r.cur]) + $past(s_r.idx[s_r.cur]));
  endproperty
  a_index: assert property (p_index) else $error("index add wrong");

  property p_modHigh;
    @(posedge clk) disable iff (rst) (accDone && s_r.mode == MODE_MODULO && !cfgWrEn)
      |=> ((s_r.ptr[$past(s_r.cur)] & ~modMask($past(s_r.ySel ? s_r.modY : s_r.modX)))
           == ($past(s_r.ptr[s_r.cur]) & ~modMask($past(s_r.ySel ? s_r.modY : s_r.modX))));
  endproperty
  a_modHigh: assert property (p_modHigh) else $error("modulo high part changed");

  property p_bitrev;
    @(posedge clk) disable iff (rst) ($rose(s_r.strobe) && s_r.mode == MODE_BITREV && !$past(cfgWrEn))
      |-> (memAddr == bitReverse(s_r.ptr[s_r.cur]));
  endproperty
  a_bitrev: assert property (p_bitrev) else $error("bit-reverse address wrong");

  property p_imm;
    @(posedge clk) disable iff (rst) (accDone && s_r.mode == MODE_IMM && !cfgWrEn)
      |=> (s_r.ptr[$past(s_r.cur)] == $past(s_r.ptr[s_r.cur]) + $past(s_r.imm));
  endproperty
  a_imm: assert property (p_imm) else $error("immediate add wrong");

  property p_side;
    @(posedge clk) disable iff (rst) memStrobe |-> (memYSel == s_r.cur[`DAG_Y_BIT]);
  endproperty
  a_side: assert property (p_side) else $error("wrong memory space");

  property p_extWait;
    @(posedge clk) disable iff (rst) (memStrobe && waitLeft != `DAG_WAIT_ZERO) |-> !accDone;
  endproperty
  a_extWait: assert property (p_extWait) else $error("ended before waits");

  property p_intFast;
    @(posedge clk) disable iff (rst) (waitStart && !extNow) |=> (ce |-> accDone);
  endproperty
  a_intFast: assert property (p_intFast) else $error("internal access stalled");

  c_extSeven: cover property (@(posedge clk) $rose(memStrobe) && memExt && waitLeft == `DAG_WAIT_C7);
  c_modulo: cover property (@(posedge clk) accDone && s_r.mode == MODE_MODULO);
  c_bitrev: cover property (@(posedge clk) accDone && s_r.mode == MODE_BITREV && memYSel);
endmodule : data_address_generator
`default_nettype wire

/* File: dv/ext_mem_model.sv */
// External data memory model that stretches accesses with its wait pin
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  // Clock
  input wire logic clk,
  // Memory side of the generator
  input wire logic memStrobe,
  input wire logic memExt,
  // Bench control
  input wire logic [7:0] holdLen,
  output logic waitReqPin
);
  logic [7:0] cnt = 8'h00;
  logic busy = 1'b0;

  // Raised early in the access, well before it could otherwise end
  always @(posedge clk)
  begin
    busy <= memStrobe;
    if (memStrobe && memExt && !busy)
      cnt <= holdLen;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  end

  assign waitReqPin = (cnt != 8'h00);
endmodule : ext_mem_model
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench of the data address generator
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dag_pkg::*;
  typedef struct packed {
    logic [2:0] p;
    mode_t m;
    logic [15:0] init, idx, imm, addr, nxt;
  } row_t;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, accValid = 1'b0, cfgWrEn = 1'b0;
  logic [2:0] accPtr = 3'h0, cfgWrIdx = 3'h0, rdIdx = 3'h0;
  mode_t accMode = MODE_HOLD;
  cfg_target_t cfgWrTarget = TGT_POINTER;
  logic [15:0] accImm = 16'h0000, cfgWrData = 16'h0000, memAddr, rdPtr, seenAddr;
  logic accReady, accDone, memStrobe, memYSel, memExt, waitReqPin;
  logic [7:0] holdLen = 8'h00;
  logic [15:0] waitExp [4] = '{16'h0000, 16'h0001, 16'h0003, 16'h0007};
  int err_total = 0, num_checks = 0, cyc = 0, tick = 0;
  row_t r;
  row_t rows [12] = '{
    '{3'h0, MODE_HOLD, 16'h0010, 16'h0000, 16'h0000, 16'h0010, 16'h0010},
    '{3'h1, MODE_INC, 16'h0010, 16'h0000, 16'h0000, 16'h0010, 16'h0011},
    '{3'h2, MODE_DEC, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hffff},
    '{3'h3, MODE_INDEX, 16'h0100, 16'hfffe, 16'h0000, 16'h0100, 16'h00fe},
    '{3'h4, MODE_INC, 16'h00ff, 16'h0000, 16'h0000, 16'h00ff, 16'h0100},
    '{3'h6, MODE_INDEX, 16'h1000, 16'h0010, 16'h0000, 16'h1000, 16'h1010},
    '{3'h7, MODE_IMM, 16'h2000, 16'h0000, 16'h0005, 16'h2000, 16'h2005},
    '{3'h0, MODE_MODULO, 16'h0108, 16'h0003, 16'h0000, 16'h0108, 16'h0101},
    '{3'h5, MODE_MODULO, 16'h0204, 16'h0002, 16'h0000, 16'h0204, 16'h0200},
    '{3'h1, MODE_BITREV, 16'h0002, 16'h0002, 16'h0000, 16'h4000, 16'h0004},
    '{3'h6, MODE_BITREV, 16'h0004, 16'h0001, 16'h0000, 16'h2000, 16'h0005},
    '{3'h4, MODE_MODULO, 16'h0201, 16'hfffd, 16'h0000, 16'h0201, 16'h0204}};

  always #2.5 clk = ~clk;

  data_address_generator data_address_generator_i (.clk(clk), .rst(rst), .ce(ce),
    .accValid(accValid), .accReady(accReady), .accPtr(accPtr), .accMode(accMode),
    .accImm(accImm), .accDone(accDone), .memAddr(memAddr), .memStrobe(memStrobe),
    .memYSel(memYSel), .memExt(memExt), .waitReqPin(waitReqPin), .cfgWrEn(cfgWrEn),
    .cfgWrTarget(cfgWrTarget), .cfgWrIdx(cfgWrIdx), .cfgWrData(cfgWrData),
    .rdIdx(rdIdx), .rdPtr(rdPtr));

  ext_mem_model ext_mem_model_i (.clk(clk), .memStrobe(memStrobe), .memExt(memExt),
    .holdLen(holdLen), .waitReqPin(waitReqPin));

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cfg(input cfg_target_t t, input logic [2:0] i, input logic [15:0] d);
    @(posedge clk);
    cfgWrEn <= 1'b1;
    cfgWrTarget <= t;
    cfgWrIdx <= i;
    cfgWrData <= d;
    @(posedge clk);
    cfgWrEn <= 1'b0;
  endtask : cfg

  // Returns in the done cycle; cyc counts cycles beyond the first
  task automatic acc(input logic [2:0] p, input mode_t m, input logic [15:0] imm);
    @(posedge clk);
    accValid <= 1'b1;
    accPtr <= p;
    accMode <= m;
    accImm <= imm;
    @(posedge clk);
    accValid <= 1'b0;
    #1;
    cyc = 0;
    while (accDone !== 1'b1 && cyc < 200)
    begin
      @(posedge clk);
      #1;
      cyc++;
    end
    seenAddr = memAddr;
    chk("accDone", 16'(accDone), 16'h0001);
  endtask : acc

  task automatic rd(input logic [2:0] p, input logic [15:0] exp);
    @(posedge clk);
    rdIdx <= p;
    repeat (2) @(posedge clk);
    #1;
    chk("pointer", rdPtr, exp);
  endtask : rd

  always @(posedge clk)
  begin
    tick <= tick + 1;
    if (tick == 20000)
    begin
      err_total++;
      conclude();
    end
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("accReady", 16'(accReady), 16'h0001);
    chk("memStrobe", 16'(memStrobe), 16'h0000);
    chk("rdPtr", rdPtr, 16'h0000);
    $display("test reset done");
    cfg(TGT_XMOD, 3'h0, 16'h0009);
    cfg(TGT_YMOD, 3'h0, 16'h0005);
    foreach (rows[i])
    begin
      r = rows[i];
      cfg(TGT_POINTER, r.p, r.init);
      cfg(TGT_INDEX, r.p, r.idx);
      acc(r.p, r.m, r.imm);
      chk("memAddr", seenAddr, r.addr);
      chk("memYSel", 16'(memYSel), 16'(r.p[2]));
      rd(r.p, r.nxt);
    end
    $display("test table done");
    // Back-to-back use of one pointer
    cfg(TGT_POINTER, 3'h1, 16'h0041);
    acc(3'h1, MODE_INC, 16'h0000);
    acc(3'h1, MODE_INC, 16'h0000);
    chk("memAddr", seenAddr, 16'h0042);
    // Request under a frozen clock enable must not move anything
    @(posedge clk);
    ce <= 1'b0;
    accValid <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("memStrobe", 16'(memStrobe), 16'h0000);
    @(posedge clk);
    ce <= 1'b1;
    accValid <= 1'b0;
    rd(3'h1, 16'h0043);
    $display("test back to back done");
    for (int c = 0; c < 4; c++)
    begin
      cfg(TGT_WAIT, 3'h0, 16'(c));
      cfg(TGT_POINTER, 3'h0, 16'hc000);
      acc(3'h0, MODE_HOLD, 16'h0000);
      chk("memExt", 16'(memExt), 16'h0001);
      chk("waits", 16'(cyc), waitExp[c]);
    end
    cfg(TGT_WAIT, 3'h0, 16'h0008);
    cfg(TGT_POINTER, 3'h4, 16'hffff);
    acc(3'h4, MODE_HOLD, 16'h0000);
    chk("waitsY", 16'(cyc), 16'h0003);
    cfg(TGT_WAIT, 3'h0, 16'h000f);
    cfg(TGT_POINTER, 3'h0, 16'hbfff);
    acc(3'h0, MODE_HOLD, 16'h0000);
    chk("memExt", 16'(memExt), 16'h0000);
    chk("waits", 16'(cyc), 16'h0000);
    $display("test wait codes done");
    // Pin held past the programmed seven waits
    cfg(TGT_POINTER, 3'h0, 16'hc000);
    holdLen <= 8'h0c;
    acc(3'h0, MODE_HOLD, 16'h0000);
    holdLen <= 8'h00;
    // Pin high twelve cycles from the second access cycle, seen two flops late
    chk("pinWait", 16'(cyc), 16'h000f);
    $display("test wait pin done");
    // Reset in the middle of an external access
    cfg(TGT_POINTER, 3'h0, 16'hc000);
    @(posedge clk);
    accValid <= 1'b1;
    accPtr <= 3'h0;
    accMode <= MODE_INC;
    @(posedge clk);
    accValid <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("memStrobe", 16'(memStrobe), 16'h0000);
    chk("accReady", 16'(accReady), 16'h0001);
    rd(3'h0, 16'h0000);
    acc(3'h0, MODE_INC, 16'h0000);
    chk("waits", 16'(cyc), 16'h0000);
    rd(3'h0, 16'h0001);
    $display("test mid reset done");
    conclude();
  end
endmodule : tb
`default_nettype wire
